/* File: comparator_params.svh */
// Purpose: Named constants for the comparator control bank.
// Assumes: Included by bare name wherever the constants are needed.
// Notes:   Offsets are byte addresses on the APB register bus.
`ifndef COMPARATOR_PARAMS_SVH
`define COMPARATOR_PARAMS_SVH

`define NUM_CHANNELS       3
`define CTRL_OFFSET        12'h000
`define INSEL_OFFSET       12'h004
`define RESULT_LSB         5
`define ENABLE_LSB         0
`define CTRL_WIDTH         8
`define CTRL_RESET         8'h00
`define INSEL_RESET        3'h0
`define SYNC_STAGES        2

`endif

/* File: comparator_pkg.sv */
// Purpose: Types shared by the comparator control bank modules.
// Assumes: comparator_params.svh supplies the channel count.
// Notes:   All state of each module is held in one packed struct.
`include "comparator_params.svh"

package comparator_pkg;

  typedef logic [`NUM_CHANNELS-1:0] chan_vec_t;

  typedef struct packed {
    chan_vec_t   stage1;
    chan_vec_t   stage2;
  } sync_state_t;

  typedef struct packed {
    chan_vec_t   enable;
    chan_vec_t   input_select;
    chan_vec_t   result;
    logic [31:0] read_data;
    logic        slave_error;
  } bank_state_t;

endpackage : comparator_pkg

/* File: comparator_sync.sv */
// Purpose: Two-flop synchroniser for the analog comparator decisions.
// Assumes: Decisions change asynchronously to the core clock.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ns
`default_nettype none
`include "comparator_params.svh"

module comparator_sync
  import comparator_pkg::*;
#(
  parameter int WIDTH = `NUM_CHANNELS
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             reset,
  // Raw and synchronised decisions.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // The state struct is sized by the channel count, so WIDTH must match it.
  if (WIDTH != `NUM_CHANNELS) begin : g_bad_width
    $error("comparator_sync: WIDTH must equal the channel count");
  end

  sync_state_t state;
  sync_state_t next_state;

  always_comb begin
    next_state        = state;
    next_state.stage1 = async_in;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stage2;

endmodule : comparator_sync

`default_nettype wire

/* File: comparator_control_bank.sv */
// Purpose: Comparator control register bank behind an APB slave port.
// Assumes: Analog comparators and input muxes sit outside this module.
// Notes:   No wait states; read data is captured at the setup edge.
//
// Overview of operation
// - Three channels, each own enable and result.
// - Inputs selectable between pins and reference.
// - Results reach software only, never pins.
// - Results in bits 7..5, read-only.
// - Result is one when positive input higher.
// - Enables in bits 2..0, read/write.
// - All implemented bits clear at reset.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "comparator_params.svh"

module comparator_control_bank
  import comparator_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  // Clock and reset.
  input  wire logic                    REF_CLK,
  input  wire logic                    RESET,
  // APB slave port.
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [ADDR_WIDTH-1:0]   PADDR,
  input  wire logic [31:0]             PWDATA,
  input  wire logic [3:0]              PSTRB,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  // Analog comparator interface.
  input  wire logic [`NUM_CHANNELS-1:0] COMPARATOR_DECISION,
  output logic      [`NUM_CHANNELS-1:0] CHANNEL_ENABLE,
  output logic      [`NUM_CHANNELS-1:0] CHANNEL_INPUT_SELECT
);

  // The decoder needs room for the highest register offset.
  if (ADDR_WIDTH < 3 || ADDR_WIDTH > 32) begin : g_bad_addr_width
    $error("comparator_control_bank: ADDR_WIDTH must be 3 to 32");
  end

  localparam logic [ADDR_WIDTH-1:0] CTRL_ADDR  =
    ADDR_WIDTH'(`CTRL_OFFSET);
  localparam logic [ADDR_WIDTH-1:0] INSEL_ADDR =
    ADDR_WIDTH'(`INSEL_OFFSET);
  localparam logic [`CTRL_WIDTH-1:0] CTRL_RESET_VALUE = `CTRL_RESET;

  bank_state_t state;
  bank_state_t next_state;
  chan_vec_t   decision_sync;

  // Decisions arrive from analog logic with no clock relation.
  comparator_sync #(
    .WIDTH    (`NUM_CHANNELS)
  ) u_sync (
    .clk      (REF_CLK),
    .reset    (RESET),
    .async_in (COMPARATOR_DECISION),
    .sync_out (decision_sync)
  );

  // Assembles the 8-bit control view; bits 4 and 3 stay zero.
  function automatic logic [31:0] ctrl_view(input chan_vec_t res,
                                            input chan_vec_t en);
    logic [31:0] v;
    v = '0;
    v[`RESULT_LSB +: `NUM_CHANNELS] = res;
    v[`ENABLE_LSB +: `NUM_CHANNELS] = en;
    return v;
  endfunction : ctrl_view

  logic setup_phase;
  logic access_phase;
  logic hit_ctrl;
  logic hit_insel;

  assign setup_phase  = PSEL && !PENABLE;
  assign access_phase = PSEL && PENABLE;

  always_comb begin
    hit_ctrl  = 1'b0;
    hit_insel = 1'b0;
    if (PADDR == CTRL_ADDR) begin
      hit_ctrl = 1'b1;
    end else if (PADDR == INSEL_ADDR) begin
      hit_insel = 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    // A disabled channel reports zero; an enabled one tracks its decision.
    next_state.result = decision_sync & state.enable;
    if (setup_phase) begin
      next_state.slave_error = !(hit_ctrl || hit_insel);
      if (hit_ctrl) begin
        // Masking with the live enable hides a result taken before a disable.
        next_state.read_data = ctrl_view(state.result & state.enable,
                                         state.enable);
      end else if (hit_insel) begin
        next_state.read_data = {29'h0000000, state.input_select};
      end else begin
        next_state.read_data = '0;
      end
    end
    if (access_phase && PWRITE && PSTRB[0]) begin
      // Only the enable field is writable; results and gap bits ignore it.
      if (hit_ctrl) begin
        next_state.enable =
          PWDATA[`ENABLE_LSB +: `NUM_CHANNELS];
      end else if (hit_insel) begin
        next_state.input_select = PWDATA[`NUM_CHANNELS-1:0];
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state.enable       <= CTRL_RESET_VALUE[`ENABLE_LSB +: `NUM_CHANNELS];
      state.result       <= CTRL_RESET_VALUE[`RESULT_LSB +: `NUM_CHANNELS];
      state.input_select <= `INSEL_RESET;
      state.read_data    <= '0;
      state.slave_error  <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Results leave only through PRDATA; no pin carries them.
  assign PRDATA               = state.read_data;
  assign PREADY               = access_phase;
  assign PSLVERR              = access_phase && state.slave_error;
  assign CHANNEL_ENABLE       = state.enable;
  assign CHANNEL_INPUT_SELECT = state.input_select;

endmodule : comparator_control_bank

`default_nettype wire

/* File: comparator_control_bank_chk.sv */
// Purpose: Port assertions for the comparator bank.
// Assumes: Zero-wait APB slave.
// Notes: Bound to the bank.
`timescale 1ns/1ns
`default_nettype none
`include "comparator_params.svh"
module comparator_control_bank_chk #(parameter int ADDR_WIDTH = 12) (
  input wire logic REF_CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
  input wire logic [ADDR_WIDTH-1:0] PADDR,
  input wire logic [31:0] PWDATA, PRDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [`NUM_CHANNELS-1:0] COMPARATOR_DECISION, CHANNEL_ENABLE,
  input wire logic [`NUM_CHANNELS-1:0] CHANNEL_INPUT_SELECT
);
  wire acc = PSEL && PENABLE;
  wire ctl = PADDR == 0;
  wire map = ctl || PADDR == 4;
  wire rd = PSEL && !PENABLE && !PWRITE && ctl;
  wire wr = acc && PWRITE && ctl && PSTRB[0];
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  a_ready_now: assert property (PREADY == acc) else $error("ready");
  a_err_bad: assert property (acc && !map |-> PSLVERR && PRDATA == 0)
    else $error("bad");
  a_err_good: assert property (acc && map |-> !PSLVERR) else $error("err");
  a_en_write: assert property (wr |=> CHANNEL_ENABLE == $past(PWDATA[2:0]))
    else $error("wr");
  a_en_hold: assert property (!wr |=> $stable(CHANNEL_ENABLE))
    else $error("hold");
  a_rd_zero: assert property (rd |=> PRDATA[31:8] == 0 && PRDATA[4:3] == 0)
    else $error("zero");
  a_rd_en: assert property (rd |=> PRDATA[2:0] == CHANNEL_ENABLE)
    else $error("rden");
  a_rd_off: assert property (rd |=> (PRDATA[7:5] & ~CHANNEL_ENABLE) == 0)
    else $error("off");
  a_res_bits: assert property (($stable(COMPARATOR_DECISION)
    && $stable(CHANNEL_ENABLE))[*5] ##0 rd
    |=> PRDATA[7:5] == $past(COMPARATOR_DECISION & CHANNEL_ENABLE))
    else $error("res");
  a_rst_clr: assert property (disable iff (1'b0) RESET |->
    CHANNEL_ENABLE == 0 && CHANNEL_INPUT_SELECT == 0 && PRDATA == 0)
    else $error("rst");
  c_bad: cover property (acc && !map);
  c_wr: cover property (wr);
  c_res: cover property (rd ##1 PRDATA[7:5] != 0);
endmodule : comparator_control_bank_chk
bind comparator_control_bank comparator_control_bank_chk #(
  .ADDR_WIDTH           (ADDR_WIDTH)
) chk (
  .REF_CLK              (REF_CLK),
  .RESET                (RESET),
  .PSEL                 (PSEL),
  .PENABLE              (PENABLE),
  .PWRITE               (PWRITE),
  .PREADY               (PREADY),
  .PSLVERR              (PSLVERR),
  .PADDR                (PADDR),
  .PWDATA               (PWDATA),
  .PRDATA               (PRDATA),
  .PSTRB                (PSTRB),
  .COMPARATOR_DECISION  (COMPARATOR_DECISION),
  .CHANNEL_ENABLE       (CHANNEL_ENABLE),
  .CHANNEL_INPUT_SELECT (CHANNEL_INPUT_SELECT)
);
`default_nettype wire

/* File: comparator_control_bank_tb.sv */
// Purpose: Self-checking bench for the comparator bank.
// Assumes: Control at 0x000, select at 0x004.
// Notes: Results settle three edges after a change.
`timescale 1ns/1ns
`default_nettype none
module comparator_control_bank_tb;
  logic REF_CLK = 0, RESET, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY;
  logic PSLVERR, er;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rd;
  logic [3:0] PSTRB = '0;
  logic [2:0] COMPARATOR_DECISION = '0, CHANNEL_ENABLE, CHANNEL_INPUT_SELECT;
  int miscompares = 0, n_tests = 0;
  comparator_control_bank dut (.*);
  always #5 REF_CLK = ~REF_CLK;
  task chk(input string n, input logic [31:0] e, s);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [3:0] s);
    @(posedge REF_CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} <= {2'b10, w, a, d, s};
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    // Only the watchdog ends a wait that never sees ready.
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
    #1;
  endtask : apb
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task t_reset;
    apb(1'b0, 12'h000, '0, 4'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, 12'h004, '0, 4'h0);
    chk("select", 32'h0, rd);
    $display("reset test done");
  endtask : t_reset
  task t_enable;
    for (int v = 0; v < 8; v++) begin
      apb(1'b1, 12'h000, 32'hf8 | v, 4'hf);
      chk("enable", v, CHANNEL_ENABLE);
      apb(1'b0, 12'h000, '0, 4'h0);
      chk("ctrl", v, rd);
    end
    apb(1'b1, 12'h000, 32'h2, 4'he);
    chk("strobe", 32'h7, CHANNEL_ENABLE);
    $display("enable test done");
  endtask : t_enable
  task t_result;
    @(posedge REF_CLK) COMPARATOR_DECISION <= 3'h5;
    repeat (6) @(posedge REF_CLK);
    apb(1'b0, 12'h000, '0, 4'h0);
    chk("results", 32'ha7, rd);
    @(posedge REF_CLK) COMPARATOR_DECISION <= 3'h6;
    apb(1'b1, 12'h000, 32'h3, 4'h1);
    repeat (6) @(posedge REF_CLK);
    apb(1'b0, 12'h000, '0, 4'h0);
    chk("results", 32'h43, rd);
    $display("result test done");
  endtask : t_result
  task t_bad;
    apb(1'b1, 12'h008, 32'h0, 4'hf);
    chk("error", 32'h1, er);
    chk("enable", 32'h3, CHANNEL_ENABLE);
    apb(1'b0, 12'h00c, '0, 4'h0);
    chk("bad data", 32'h0, rd);
    apb(1'b1, 12'h004, 32'h5, 4'hf);
    chk("error", 32'h0, er);
    chk("select", 32'h5, CHANNEL_INPUT_SELECT);
    apb(1'b0, 12'h004, '0, 4'h0);
    chk("select", 32'h5, rd);
    $display("address test done");
  endtask : t_bad
  task t_mid_reset;
    apb(1'b1, 12'h000, 32'h5, 4'h1);
    chk("enable", 32'h5, CHANNEL_ENABLE);
    @(posedge REF_CLK) RESET <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    RESET <= 1'b0;
    #1;
    chk("enable", 32'h0, CHANNEL_ENABLE);
    chk("select", 32'h0, CHANNEL_INPUT_SELECT);
    apb(1'b0, 12'h000, '0, 4'h0);
    chk("ctrl", 32'h0, rd);
    $display("mid reset test done");
  endtask : t_mid_reset
  initial begin
    RESET <= 1'b1;
    repeat (12) @(posedge REF_CLK);
    RESET <= 1'b0;
    t_reset;
    t_enable;
    t_result;
    t_bad;
    t_mid_reset;
    stop_test;
  end
  // The tests need about 116 cycles; this allows over forty times that.
  initial begin
    #50000;
    miscompares++;
    stop_test;
  end
endmodule : comparator_control_bank_tb
`default_nettype wire
